// file: rtl/latency_defs.svh
// Purpose: register map, field layout and fixed figures of the latency model
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes: definitions only
`ifndef LATENCY_DEFS_SVH
`define LATENCY_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CFG 8'h00
`define OFF_FRAME 8'h04
`define OFF_LAT 8'h08
`define OFF_TOTAL 8'h0c
`define OFF_REC 8'h10

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define CFG_PATH 1:0
`define CFG_DEC 7:2
`define CFG_CPLX 8
`define CFG_M 15:12
`define CFG_L 19:16
`define CFG_RST 32'h0001_1000
`define FRM_S 4:0
`define FRM_K 12:8
`define FRM_RST 32'h0000_0101
`define LAT_ADC 10:0
`define LAT_LINK 26:16
`define LAT_UNSUP 31
`define REC_VALID 31
`define REC_UNSUP 12

// ----------------------------------------------------------------
// fixed latency figure in encode clock cycles and table row and column codes
// ----------------------------------------------------------------
`define LAT_FULL_BW 11'h01f
`define ROW_NONE 5'h1f
`define ROW_REAL_ONLY 5'h06
`define COL_MID 3'h3

`endif

// file: rtl/latency_model.sv
// Purpose: deterministic sample-path latency model with register access
// Assumes: link_up_valid comes from logic on ref_clk (250 MHz)
// Notes: one record per link establishment is queued for software
`timescale 1ns/1ps
`include "latency_defs.svh"
module latency_model
    import latency_pkg::*;
#(
    parameter lat_t FS4_ADC_LAT = 11'h01f,
    parameter int REC_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic link_up_valid,
    output logic link_up_ready,
    output lat_t adc_to_lmfc_lat,
    output lat_t lmfc_to_out_lat,
    output logic [11:0] total_lat,
    output logic cfg_unsupported,
    output logic [9:0] lmfc_div
);
    localparam int REC_W = 13;

    // ----------------------------------------------------------------
    // link stage table
    // ----------------------------------------------------------------
    // columns left to right are M/L 0.125, 0.25 .. 8; zero is no entry
    function automatic lat_t link_table(
        input logic [4:0] row,
        input logic [2:0] col
    );
        logic [76:0] v;
        v = '0;
        case (row)
            5'h00: v = {11'h052, 11'h02c, 11'h019, 11'h00e,
                        11'h007, 11'h009, 11'h003};
            5'h01: v = {11'h000, 11'h02e, 11'h000, 11'h000,
                        11'h000, 11'h000, 11'h000};
            5'h02: v = {11'h052, 11'h02c, 11'h019, 11'h00e,
                        11'h007, 11'h000, 11'h000};
            5'h03: v = {11'h0a0, 11'h054, 11'h02e, 11'h01b,
                        11'h00e, 11'h007, 11'h000};
            5'h04: v = {11'h0ed, 11'h07c, 11'h043, 11'h027,
                        11'h015, 11'h00b, 11'h000};
            5'h05: v = {11'h13b, 11'h0a4, 11'h058, 11'h032,
                        11'h01b, 11'h00e, 11'h009};
            5'h06: v = {11'h000, 11'h0cb, 11'h06d, 11'h03e,
                        11'h02b, 11'h000, 11'h000};
            5'h07: v = {11'h000, 11'h0f3, 11'h082, 11'h049,
                        11'h027, 11'h015, 11'h00e};
            5'h08: v = {11'h000, 11'h143, 11'h0ac, 11'h060,
                        11'h032, 11'h01b, 11'h012};
            5'h09: v = {11'h000, 11'h000, 11'h0d5, 11'h077,
                        11'h03e, 11'h021, 11'h016};
            5'h0a: v = {11'h000, 11'h000, 11'h0ff, 11'h08e,
                        11'h049, 11'h027, 11'h01b};
            5'h0b: v = {11'h000, 11'h000, 11'h13e, 11'h0b0,
                        11'h05a, 11'h02f, 11'h021};
            5'h0c: v = {11'h000, 11'h000, 11'h153, 11'h0bc,
                        11'h060, 11'h032, 11'h023};
            5'h0d: v = {11'h000, 11'h000, 11'h000, 11'h0e9,
                        11'h077, 11'h03e, 11'h02b};
            5'h0e: v = {11'h000, 11'h000, 11'h000, 11'h117,
                        11'h08e, 11'h049, 11'h033};
            5'h0f: v = {11'h000, 11'h000, 11'h000, 11'h15c,
                        11'h0b0, 11'h05a, 11'h03e};
            5'h10: v = {11'h000, 11'h000, 11'h000, 11'h000,
                        11'h0e9, 11'h077, 11'h052};
            5'h11: v = {11'h000, 11'h000, 11'h000, 11'h000,
                        11'h117, 11'h08e, 11'h061};
            default: v = '0;
        endcase
        return v[(6 - int'(col)) * 11 +: 11];
    endfunction : link_table

    function automatic logic cplx_only(input logic [4:0] row);
        case (row)
            5'h0b, 5'h0c, 5'h0f, 5'h10, 5'h11: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : cplx_only

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [31:0] cfg_reg, frame_reg;
    bus_state_t state_reg;
    logic wr_accept, rd_accept, pop;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] din,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = din[i*8 +: 8];
        end
        return r;
    endfunction : merge

    assign wr_accept = state_reg == BUS_ACK && avs_write;
    assign rd_accept = state_reg == BUS_ACK && avs_read;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= `CFG_RST;
            frame_reg <= `FRM_RST;
        end else if (ce && wr_accept) begin
            if (avs_address == `OFF_CFG) begin
                cfg_reg <= merge(cfg_reg, avs_writedata, avs_byteenable);
            end
            if (avs_address == `OFF_FRAME) begin
                frame_reg <= merge(frame_reg, avs_writedata,
                                   avs_byteenable);
            end
        end
    end

    // ----------------------------------------------------------------
    // latency lookup
    // ----------------------------------------------------------------
    logic [4:0] row;
    logic [2:0] col;
    logic col_ok, cplx, unsup;
    lat_t adc_lat, link_lat;

    assign cplx = cfg_reg[`CFG_CPLX];

    stage_lookup #(
        .FS4_ADC_LAT(FS4_ADC_LAT)
    ) u_lookup (
        .path(cfg_reg[`CFG_PATH]),
        .dec(cfg_reg[`CFG_DEC]),
        .cplx(cplx),
        .conv_cnt(cfg_reg[`CFG_M]),
        .lane_cnt(cfg_reg[`CFG_L]),
        .row(row),
        .col(col),
        .col_ok(col_ok),
        .adc_lat(adc_lat)
    );

    // data type never enters the link stage lookup
    assign link_lat = link_table(row, col);

    always_comb begin
        unsup = 1'b0;
        if (row == `ROW_NONE || !col_ok) unsup = 1'b1;
        if (link_lat == '0 || adc_lat == '0) unsup = 1'b1;
        if (row == `ROW_REAL_ONLY && cplx) unsup = 1'b1;
        if (cplx_only(row) && !cplx) unsup = 1'b1;
    end

    // a pure function of the configuration, so every link-up sees it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adc_to_lmfc_lat <= '0;
            lmfc_to_out_lat <= '0;
            total_lat <= '0;
            cfg_unsupported <= 1'b1;
        end else if (ce) begin
            cfg_unsupported <= unsup;
            if (unsup) begin
                adc_to_lmfc_lat <= '0;
                lmfc_to_out_lat <= '0;
                total_lat <= '0;
            end else begin
                adc_to_lmfc_lat <= adc_lat;
                lmfc_to_out_lat <= link_lat;
                total_lat <= {1'b0, adc_lat} + {1'b0, link_lat};
            end
        end
    end

    // lmfc period in converter clocks is S times K
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lmfc_div <= '0;
        end else if (ce) begin
            lmfc_div <= 10'(frame_reg[`FRM_S]) * 10'(frame_reg[`FRM_K]);
        end
    end

    // ----------------------------------------------------------------
    // link-up record queue
    // ----------------------------------------------------------------
    logic rec_valid;
    logic [REC_W-1:0] rec_data;

    // records hold the registered result, one cycle behind the config
    rec_fifo #(
        .WIDTH(REC_W),
        .DEPTH(REC_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(link_up_valid),
        .in_ready(link_up_ready),
        .in_data({cfg_unsupported, total_lat}),
        .out_valid(rec_valid),
        .out_ready(pop),
        .out_data(rec_data)
    );
    // pop only what the latched read showed; a late record stays queued
    assign pop = ce && rd_accept && avs_address == `OFF_REC
        && avs_readdata[`REC_VALID];

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    // one wait cycle: data is latched on the first cycle of a request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            case (state_reg)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_reg <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    state_reg <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    state_reg <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            `OFF_CFG: rd_mux = cfg_reg;
            `OFF_FRAME: rd_mux = frame_reg;
            `OFF_LAT: begin
                rd_mux[`LAT_ADC] = adc_to_lmfc_lat;
                rd_mux[`LAT_LINK] = lmfc_to_out_lat;
                rd_mux[`LAT_UNSUP] = cfg_unsupported;
            end
            `OFF_TOTAL: rd_mux[11:0] = total_lat;
            `OFF_REC: begin
                rd_mux[`REC_VALID] = rec_valid;
                if (rec_valid) rd_mux[`REC_UNSUP:0] = rec_data;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (ce && state_reg == BUS_IDLE && avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_dec4_half;
        @(posedge ref_clk) disable iff (rst)
        ce && row == 5'h05 && cplx && col == 3'h2 && col_ok
        |=> adc_to_lmfc_lat == 11'h0a2 && lmfc_to_out_lat == 11'h058
            && total_lat == 12'h0fa;
    endproperty
    a_dec4_half: assert property (p_dec4_half)
        else $error("dec4 complex at half ratio not 162 plus 88");

    property p_sum;
        @(posedge ref_clk) disable iff (rst)
        !cfg_unsupported |->
            total_lat == {1'b0, adc_to_lmfc_lat} + {1'b0, lmfc_to_out_lat};
    endproperty
    a_sum: assert property (p_sum)
        else $error("total is not the sum of both stages");

    property p_unsup_zero;
        @(posedge ref_clk) disable iff (rst)
        cfg_unsupported |-> total_lat == '0 && adc_to_lmfc_lat == '0;
    endproperty
    a_unsup_zero: assert property (p_unsup_zero)
        else $error("unsupported setup still reports a latency");

    property p_full_bw;
        @(posedge ref_clk) disable iff (rst)
        ce && cfg_reg[`CFG_PATH] == PATH_FULL
        |=> cfg_unsupported || adc_to_lmfc_lat == 11'h01f;
    endproperty
    a_full_bw: assert property (p_full_bw)
        else $error("full bandwidth stage is not 31 cycles");

    property p_real_only;
        @(posedge ref_clk) disable iff (rst)
        ce && cfg_reg[`CFG_PATH] == PATH_DEC
        && cfg_reg[`CFG_DEC] == 6'h05 && cplx |=> cfg_unsupported;
    endproperty
    a_real_only: assert property (p_real_only)
        else $error("complex decimate-by-five accepted");

    property p_cplx_only;
        @(posedge ref_clk) disable iff (rst)
        ce && cfg_reg[`CFG_PATH] == PATH_DEC && !cplx
        && cfg_reg[`CFG_DEC] inside {6'h0f, 6'h10, 6'h1e, 6'h28, 6'h30}
        |=> cfg_unsupported;
    endproperty
    a_cplx_only: assert property (p_cplx_only)
        else $error("real output accepted for complex-only mode");

    property p_bad_lanes;
        @(posedge ref_clk) disable iff (rst)
        ce && (cfg_reg[`CFG_L] == 4'h0 || cfg_reg[`CFG_L] == 4'h3)
        |=> cfg_unsupported;
    endproperty
    a_bad_lanes: assert property (p_bad_lanes)
        else $error("lane count without a ratio column accepted");

    property p_stable;
        @(posedge ref_clk) disable iff (rst)
        ce ##1 ce && $stable(cfg_reg) ##1 ce && $stable(cfg_reg)
        |-> $stable(total_lat) && $stable(cfg_unsupported);
    endproperty
    a_stable: assert property (p_stable)
        else $error("latency moved with the configuration held");

    property p_lmfc;
        @(posedge ref_clk) disable iff (rst)
        ce |=> lmfc_div ==
            $past(10'(frame_reg[`FRM_S]) * 10'(frame_reg[`FRM_K]));
    endproperty
    a_lmfc: assert property (p_lmfc)
        else $error("lmfc divider is not S times K");
    property p_type_free;
        @(posedge ref_clk) disable iff (rst)
        ce && $stable(row) && $stable(col) && $changed(cplx)
        |-> $stable(link_lat);
    endproperty
    a_type_free: assert property (p_type_free)
        else $error("link stage changed with the data type");

    property p_bus_answer;
        @(posedge ref_clk) disable iff (rst)
        ce && state_reg == BUS_IDLE && (avs_read || avs_write)
        |=> !avs_waitrequest ##1 avs_waitrequest || !ce;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not one cycle after request");
endmodule : latency_model

// file: rtl/latency_pkg.sv
// Purpose: shared types of the latency model
// Assumes: nothing
// Notes: figures live in latency_defs.svh
package latency_pkg;
    typedef enum logic [1:0] {
        PATH_FULL = 2'b00,
        PATH_FS4 = 2'b01,
        PATH_DEC = 2'b10
    } path_t;
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
    typedef logic [10:0] lat_t;
endpackage : latency_pkg

// file: rtl/rec_fifo.sv
// Purpose: synchronous valid/ready FIFO for latency records
// Assumes: DEPTH is a power of two
// Notes: in_ready is registered
`timescale 1ns/1ps
module rec_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, rd_reg;
    logic [CW-1:0] count_reg, count_next;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + CW'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'b1;
        end else if (ce) begin
            if (push) wr_reg <= wr_reg + AW'(1);
            if (pop) rd_reg <= rd_reg + AW'(1);
            count_reg <= count_next;
            in_ready <= count_next != CW'(DEPTH);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce && push) mem[wr_reg] <= in_data;
    end
endmodule : rec_fifo

// file: rtl/stage_lookup.sv
// Purpose: ratio column, mode row and converter stage latency
// Assumes: converter and lane counts are powers of two up to 8
// Notes: zero latency means the combination has no entry
`timescale 1ns/1ps
`include "latency_defs.svh"
module stage_lookup
    import latency_pkg::*;
#(
    parameter lat_t FS4_ADC_LAT = 11'h01f
) (
    input wire logic [1:0] path,
    input wire logic [5:0] dec,
    input wire logic cplx,
    input wire logic [3:0] conv_cnt,
    input wire logic [3:0] lane_cnt,
    output logic [4:0] row,
    output logic [2:0] col,
    output logic col_ok,
    output lat_t adc_lat
);
    function automatic logic [2:0] pow2_log(input logic [3:0] v);
        case (v)
            4'h1: return 3'b100;
            4'h2: return 3'b101;
            4'h4: return 3'b110;
            4'h8: return 3'b111;
            default: return 3'b000;
        endcase
    endfunction : pow2_log

    function automatic logic [4:0] dec_row(input logic [5:0] d);
        case (d)
            6'h01: return 5'h02;
            6'h02: return 5'h03;
            6'h03: return 5'h04;
            6'h04: return 5'h05;
            6'h05: return 5'h06;
            6'h06: return 5'h07;
            6'h08: return 5'h08;
            6'h0a: return 5'h09;
            6'h0c: return 5'h0a;
            6'h0f: return 5'h0b;
            6'h10: return 5'h0c;
            6'h14: return 5'h0d;
            6'h18: return 5'h0e;
            6'h1e: return 5'h0f;
            6'h28: return 5'h10;
            6'h30: return 5'h11;
            default: return `ROW_NONE;
        endcase
    endfunction : dec_row

    // real and complex chains with the same filters share a figure
    function automatic lat_t dec_lat(input logic c, input logic [5:0] d);
        case ({c, d})
            7'h01, 7'h42: return 11'h05a;
            7'h43: return 11'h066;
            7'h02, 7'h44: return 11'h0a2;
            7'h03, 7'h46: return 11'h0d4;
            7'h04, 7'h48: return 11'h124;
            7'h05, 7'h4a: return 11'h17c;
            7'h06, 7'h4c: return 11'h1a8;
            7'h0f: return 11'h1f4;
            7'h08, 7'h50: return 11'h228;
            7'h0a, 7'h54: return 11'h2b6;
            7'h0c, 7'h58: return 11'h32e;
            7'h5e: return 11'h344;
            7'h14, 7'h68: return 11'h58c;
            7'h18, 7'h70: return 11'h63a;
            default: return '0;
        endcase
    endfunction : dec_lat

    logic [2:0] lm, ll;
    assign lm = pow2_log(conv_cnt);
    assign ll = pow2_log(lane_cnt);
    assign col_ok = lm[2] && ll[2];
    // column of M/L: log2(M) - log2(L) + 3 spans 0.125 .. 8
    assign col = 3'(`COL_MID + {1'b0, lm[1:0]} - {1'b0, ll[1:0]});

    always_comb begin
        row = `ROW_NONE;
        adc_lat = '0;
        case (path)
            PATH_FULL: begin
                row = 5'h00;
                adc_lat = `LAT_FULL_BW;
            end
            PATH_FS4: begin
                row = 5'h01;
                adc_lat = FS4_ADC_LAT;
            end
            PATH_DEC: begin
                row = dec_row(dec);
                adc_lat = dec_lat(cplx, dec);
            end
            default: begin
                row = `ROW_NONE;
            end
        endcase
    end
endmodule : stage_lookup

// file: testbench/link_src.sv
// Purpose: link-up event source standing in for the receiver side
// Assumes: want is a running total of events to offer
// Notes: valid is held until taken, so a full record buffer stalls it
`timescale 1ns/1ps
module link_src (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] want,
    input wire logic link_up_ready,
    output logic link_up_valid
);
    logic [4:0] sent_reg;
    // ------------------------------------------------------------
    // event source
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sent_reg <= 5'h00;
        end else if (link_up_valid && link_up_ready) begin
            sent_reg <= sent_reg + 5'h01;
        end
    end
    // one event per link establishment, offered until taken
    assign link_up_valid = !rst && (sent_reg != want);
endmodule : link_src

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the latency model
// Assumes: ce high except in the freeze check, all byte lanes written
// Notes: expected figures come from the tables in cfgs, adcs and lnks
`timescale 1ns/1ps
`include "latency_defs.svh"
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, link_up_valid, link_up_ready, cfg_unsupported;
    logic [10:0] adc_to_lmfc_lat, lmfc_to_out_lat;
    logic [11:0] total_lat;
    logic [9:0] lmfc_div;
    logic [4:0] want = 5'h00;
    int num_errors = 0, check_count = 0, cyc = 0, m_adc = 31, m_lnk = 14;
    int seed = 32'h2d83, s, k;
    logic [31:0] q [$];
    logic [31:0] cfgs [13] = '{32'h0004_1000, 32'h0004_2112, 32'h0001_8062,
        32'h0001_1016, 32'h0001_1116, 32'h0001_1042, 32'h0001_1142,
        32'h0008_1006, 32'h0008_102a, 32'h0001_1003, 32'h0004_1001,
        32'h0003_1000, 32'h0001_1012};
    int adcs [13] = '{31, 162, 1594, 380, 0, 0, 552, 90, 0, 0, 31, 0, 292};
    int lnks [13] = '{44, 88, 51, 62, 0, 0, 188, 82, 0, 0, 46, 0, 50};
    latency_model dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_up_valid(link_up_valid),
        .link_up_ready(link_up_ready), .adc_to_lmfc_lat(adc_to_lmfc_lat),
        .lmfc_to_out_lat(lmfc_to_out_lat), .total_lat(total_lat),
        .cfg_unsupported(cfg_unsupported), .lmfc_div(lmfc_div));
    link_src src (.ref_clk(ref_clk), .rst(rst), .want(want),
        .link_up_ready(link_up_ready), .link_up_valid(link_up_valid));
    // ------------------------------------------------------------
    // clock, timeout and record monitor
    // ------------------------------------------------------------
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
        if (link_up_valid && link_up_ready) begin
            q.push_back({1'b1, 18'h0, m_adc == 0, 12'(m_adc + m_lnk)});
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rchk
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        chk(32'(avs_waitrequest), 32'h1);
        rst <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        chk(32'(adc_to_lmfc_lat), 32'd31);
        chk(32'(lmfc_to_out_lat), 32'd14);
        chk(32'(total_lat), 32'd45);
        chk(32'(lmfc_div), 32'h1);
        rchk(`OFF_CFG, `CFG_RST);
        rchk(`OFF_FRAME, `FRM_RST);
        for (int i = 0; i < 13; i++) begin
            bus(1'b1, `OFF_CFG, cfgs[i], rdv);
            m_adc = adcs[i];
            m_lnk = lnks[i];
            @(posedge ref_clk);
            #1;
            chk(32'(adc_to_lmfc_lat), 32'(m_adc));
            chk(32'(lmfc_to_out_lat), 32'(m_lnk));
            chk(32'(total_lat), 32'(m_adc + m_lnk));
            chk(32'(cfg_unsupported), 32'(m_adc == 0));
            rchk(`OFF_LAT, {m_adc == 0, 4'h0, 11'(m_lnk), 5'h0,
                11'(m_adc)});
        end
        bus(1'b1, `OFF_LAT, 32'hffff_ffff, rdv);
        rchk(`OFF_LAT, {9'h0, 7'd50, 5'h0, 11'd292});
        rchk(`OFF_TOTAL, 32'd342);
        rchk(8'h20, 32'h0);
        repeat (3) begin
            s = $random(seed) & 31;
            k = $random(seed) & 31;
            bus(1'b1, `OFF_FRAME, 32'((k << 8) | s), rdv);
            @(posedge ref_clk);
            #1;
            chk(32'(lmfc_div), 32'(s * k));
        end
        @(posedge ref_clk);
        want <= 5'd16;
        while (link_up_ready !== 1'b0) @(posedge ref_clk);
        #1;
        chk(32'(q.size()), 32'd16);
        repeat (16) rchk(`OFF_REC, q.pop_front());
        rchk(`OFF_REC, 32'h0);
        bus(1'b1, `OFF_CFG, cfgs[0], rdv);
        ce <= 1'b0;
        repeat (2) @(posedge ref_clk);
        ce <= 1'b1;
        #1;
        chk(32'(total_lat), 32'd342);
        @(posedge ref_clk);
        #1;
        chk(32'(total_lat), 32'(adcs[0] + lnks[0]));
        tally_and_finish();
    end
endmodule : tb_top
